/* File: rtl/dbgp_pin_assign.v */
`timescale 1ns/1ps
`include "dbgp_map.vh"
module dbgp_pin_assign #(
  parameter NPINS = `DBGP_NPINS
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire system_reset_n_i,
  input wire ce_i,
  input wire cfg_we_i,
  input wire [1:0] cfg_i,
  input wire trace_en_i,
  input wire [NPINS*`DBGP_AF_W-1:0] port_alt_function_select_i,
  input wire [NPINS-1:0] pad_in_i,
  input wire [NPINS-1:0] gpio_out_i,
  input wire [NPINS-1:0] gpio_oe_i,
  input wire [NPINS-1:0] gpio_pu_i,
  input wire [NPINS-1:0] gpio_pd_i,
  input wire [NPINS-1:0] alt_out_i,
  input wire [NPINS-1:0] alt_oe_i,
  input wire dbg_swdio_out_i,
  input wire dbg_swdio_oe_i,
  input wire dbg_tdo_i,
  input wire dbg_tdo_oe_i,
  input wire async_trace_output_i,
  output wire [NPINS-1:0] pad_out_o,
  output wire [NPINS-1:0] pad_oe_o,
  output wire [NPINS-1:0] pad_pu_o,
  output wire [NPINS-1:0] pad_pd_o,
  output wire [NPINS-1:0] gpio_in_o,
  output wire [NPINS-1:0] alt_in_o,
  output reg mode_select_or_serial_data_o,
  output reg test_or_serial_clock_o,
  output reg test_clock_rise_o,
  output reg test_data_in_o,
  output reg test_reset_n_o,
  output wire [1:0] cfg_o,
  output wire [NPINS-1:0] debug_owned_o
);
  reg [1:0] cfg_q;
  reg [1:0] cfg_d;
  reg [NPINS-1:0] dbg_out;
  reg [NPINS-1:0] dbg_oe;
  wire [NPINS-1:0] sync_w;
  wire [NPINS-1:0] keep_w;
  wire [NPINS-1:0] alt_sel_w;
  wire [NPINS-1:0] own_w;
  wire [NPINS-1:0] alt_w;
  wire [2*NPINS-1:0] src_w;
  wire trace_sel_w;
  // Pull pattern while a pin serves the debug port
  localparam [NPINS-1:0] PU_MASK = `DBGP_PULLUP_MASK;
  localparam [NPINS-1:0] PD_MASK = `DBGP_PULLDN_MASK;
  // Pin owner codes
  localparam [1:0] SRC_DEBUG = 2'h0;
  localparam [1:0] SRC_ALT = 2'h1;
  localparam [1:0] SRC_GPIO = 2'h2;

  // Which pins a configuration keeps on debug
  function [NPINS-1:0] keep_mask;
    input [1:0] cfg;
    begin
      case (cfg)
        `DBGP_CFG_FULL: keep_mask = {NPINS{1'b1}};
        `DBGP_CFG_NO_TRST: keep_mask = ~(5'h01 << `DBGP_PIN_TRST);
        `DBGP_CFG_SWD_ONLY: keep_mask = (5'h01 << `DBGP_PIN_TMS) | (5'h01 << `DBGP_PIN_TCK);
        `DBGP_CFG_NONE: keep_mask = {NPINS{1'b0}};
        default: keep_mask = {NPINS{1'b1}};
      endcase
    end
  endfunction

  // Released pins go to GPIO; kept pins may still be lent to another function
  function [1:0] pin_source;
    input keep;
    input alt;
    begin
      if (!keep) begin
        pin_source = SRC_GPIO;
      end else if (alt) begin
        pin_source = SRC_ALT;
      end else begin
        pin_source = SRC_DEBUG;
      end
    end
  endfunction

  always @* begin
    cfg_d = cfg_q;
    if (cfg_we_i) begin
      cfg_d = cfg_i;
    end
  end

  // config register; port reset restores it at once, system reset only on a cycle with ce_i high
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= `DBGP_CFG_RESET;
    end else if (ce_i) begin
      if (!system_reset_n_i) begin
        cfg_q <= `DBGP_CFG_RESET;
      end else begin
        cfg_q <= cfg_d;
      end
    end
  end

  assign keep_w = keep_mask(cfg_q);
  assign trace_sel_w = trace_en_i & keep_w[`DBGP_PIN_TDO];

  // serial data on mode select pin
  always @* begin
    dbg_out = {NPINS{1'b0}};
    dbg_oe = {NPINS{1'b0}};
    // Input-only debug pins are never driven by the port
    dbg_out[`DBGP_PIN_TMS] = dbg_swdio_out_i;
    dbg_oe[`DBGP_PIN_TMS] = dbg_swdio_oe_i;
    dbg_out[`DBGP_PIN_TDO] = trace_sel_w ? async_trace_output_i : dbg_tdo_i;
    dbg_oe[`DBGP_PIN_TDO] = trace_sel_w | dbg_tdo_oe_i;
  end

  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pin
      reg pin_out;
      reg pin_oe;
      reg pin_pu;
      reg pin_pd;
      assign alt_sel_w[g] = (port_alt_function_select_i[g*`DBGP_AF_W +: `DBGP_AF_W] != `DBGP_AF_DEBUG);
      assign src_w[2*g +: 2] = pin_source(keep_w[g], alt_sel_w[g]);
      assign alt_w[g] = (src_w[2*g +: 2] == SRC_ALT);
      assign own_w[g] = (src_w[2*g +: 2] == SRC_DEBUG);
      // Reset value matches the pull so no false level follows reset
      dbgp_sync #(
        .RST_VAL(PU_MASK[g])
      ) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .d_i(pad_in_i[g]),
        .q_o(sync_w[g])
      );
      assign gpio_in_o[g] = own_w[g] ? 1'b0 : sync_w[g];
      assign alt_in_o[g] = alt_w[g] ? sync_w[g] : 1'b0;
      always @* begin
        pin_out = gpio_out_i[g];
        pin_oe = gpio_oe_i[g];
        pin_pu = gpio_pu_i[g];
        pin_pd = gpio_pd_i[g];
        case (src_w[2*g +: 2])
          SRC_DEBUG: begin
            pin_out = dbg_out[g];
            pin_oe = dbg_oe[g];
            pin_pu = PU_MASK[g];
            pin_pd = PD_MASK[g];
          end
          SRC_ALT: begin
            pin_out = alt_out_i[g];
            pin_oe = alt_oe_i[g];
            pin_pu = 1'b0;
            pin_pd = 1'b0;
          end
          default: begin
            pin_out = gpio_out_i[g];
            pin_oe = gpio_oe_i[g];
            pin_pu = gpio_pu_i[g];
            pin_pd = gpio_pd_i[g];
          end
        endcase
      end
      assign pad_out_o[g] = pin_out;
      assign pad_oe_o[g] = pin_oe;
      assign pad_pu_o[g] = pin_pu;
      assign pad_pd_o[g] = pin_pd;
    end
  endgenerate

  // Debug-side inputs; released pins present idle levels so the port stays quiet
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_select_or_serial_data_o <= 1'b1;
      test_or_serial_clock_o <= 1'b0;
      test_clock_rise_o <= 1'b0;
      test_data_in_o <= 1'b1;
      test_reset_n_o <= 1'b1;
    end else if (ce_i) begin
      mode_select_or_serial_data_o <= own_w[`DBGP_PIN_TMS] ? sync_w[`DBGP_PIN_TMS] : 1'b1;
      test_or_serial_clock_o <= own_w[`DBGP_PIN_TCK] ? sync_w[`DBGP_PIN_TCK] : 1'b0;
      test_data_in_o <= own_w[`DBGP_PIN_TDI] ? sync_w[`DBGP_PIN_TDI] : 1'b1;
      test_reset_n_o <= own_w[`DBGP_PIN_TRST] ? sync_w[`DBGP_PIN_TRST] : 1'b1;
      // Rise found on the filtered clock; one pulse per edge
      test_clock_rise_o <= own_w[`DBGP_PIN_TCK] & sync_w[`DBGP_PIN_TCK] & ~test_or_serial_clock_o;
    end
  end

  assign cfg_o = cfg_q;
  assign debug_owned_o = own_w;
endmodule // dbgp_pin_assign

/* File: rtl/dbgp_map.vh */
`ifndef DBGP_MAP_VH
`define DBGP_MAP_VH
// Pin-release configuration codes
`define DBGP_CFG_FULL 2'h0
`define DBGP_CFG_NO_TRST 2'h1
`define DBGP_CFG_SWD_ONLY 2'h2
`define DBGP_CFG_NONE 2'h3
`define DBGP_CFG_RESET 2'h0
// Pin index within the five-pin group
`define DBGP_PIN_TMS 0
`define DBGP_PIN_TCK 1
`define DBGP_PIN_TDI 2
`define DBGP_PIN_TDO 3
`define DBGP_PIN_TRST 4
`define DBGP_NPINS 5
// Pull pattern per pin: bit set means pull-up / pull-down
`define DBGP_PULLUP_MASK 5'h15
`define DBGP_PULLDN_MASK 5'h02
// Alternate function code that keeps a pin on debug
`define DBGP_AF_DEBUG 4'h0
`define DBGP_AF_W 4
`endif

/* File: rtl/dbgp_sync.v */
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module dbgp_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire d_i,
  output reg q_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q_o <= RST_VAL;
    end else if (ce_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end
endmodule // dbgp_sync

/* File: test/dbgp_pin_assign_assertions.sv */
`timescale 1ns/1ps
module dbgp_pin_assign_assertions #(parameter NPINS = 5) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire system_reset_n_i,
  input wire ce_i,
  input wire cfg_we_i,
  input wire [1:0] cfg_i,
  input wire trace_en_i,
  input wire [NPINS*4-1:0] port_alt_function_select_i,
  input wire [NPINS-1:0] pad_in_i,
  input wire dbg_tdo_i,
  input wire async_trace_output_i,
  input wire [NPINS-1:0] pad_out_o,
  input wire [NPINS-1:0] pad_pd_o,
  input wire test_or_serial_clock_o,
  input wire [1:0] cfg_o,
  input wire [NPINS-1:0] debug_owned_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic [4:0] alt_nz, keep;
  always_comb for (int i = 0; i < 5; i++) alt_nz[i] = |port_alt_function_select_i[i*4 +: 4];
  assign keep = cfg_o == 2'h0 ? 5'h1F : cfg_o == 2'h1 ? 5'h0F : cfg_o == 2'h2 ? 5'h03 : 5'h00;
  // Six quiet cycles outlast the five-edge input path (four-edge synchroniser plus output register)
  sequence s_clk_quiet;
    (ce_i && debug_owned_o[1] && $stable(pad_in_i[1]))[*6];
  endsequence
  chk_cfg_load: assert property (
    cfg_we_i && ce_i && system_reset_n_i |=> cfg_o == $past(cfg_i)) else $error("cfg load");
  chk_ce_hold: assert property (
    !ce_i |=> $stable(cfg_o)) else $error("cfg moved");
  chk_sys_reset: assert property (
    !system_reset_n_i && ce_i |=> cfg_o == 2'h0) else $error("cfg not full");
  chk_own_map: assert property (
    debug_owned_o == (keep & ~alt_nz)) else $error("owner map");
  chk_clk_pull: assert property (
    debug_owned_o[1] |-> pad_pd_o[1]) else $error("clock pull");
  chk_trace_on: assert property (
    debug_owned_o[3] && trace_en_i |-> pad_out_o[3] == async_trace_output_i) else $error("trace");
  chk_trace_off: assert property (
    debug_owned_o[3] && !trace_en_i |-> pad_out_o[3] == dbg_tdo_i) else $error("data out");
  chk_clk_sync: assert property (
    s_clk_quiet |-> test_or_serial_clock_o == pad_in_i[1]) else $error("clock path");
endmodule // dbgp_pin_assign_assertions
bind dbgp_pin_assign dbgp_pin_assign_assertions #(.NPINS(NPINS)) i_dbgp_pin_assign_assertions (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .system_reset_n_i(system_reset_n_i), .ce_i(ce_i),
  .cfg_we_i(cfg_we_i), .cfg_i(cfg_i), .trace_en_i(trace_en_i),
  .port_alt_function_select_i(port_alt_function_select_i), .pad_in_i(pad_in_i), .dbg_tdo_i(dbg_tdo_i),
  .async_trace_output_i(async_trace_output_i), .pad_out_o(pad_out_o), .pad_pd_o(pad_pd_o),
  .test_or_serial_clock_o(test_or_serial_clock_o), .cfg_o(cfg_o), .debug_owned_o(debug_owned_o));

/* File: test/dbgp_probe_model.sv */
`timescale 1ns/1ps
module dbgp_probe_model (
  input wire run_i,
  output logic tck_o,
  output logic tms_o
);
  initial tck_o = 1'h0;
  initial tms_o = 1'h1;
  // Clock parked low between frames
  always #62.5 tck_o = run_i ? ~tck_o : 1'h0;
  always @(negedge tck_o) tms_o <= ~tms_o;
endmodule // dbgp_probe_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'h0, reset_n_i = 1'h0, sys_n = 1'h1, ce = 1'h1, we = 1'h0, ten = 1'h0, run = 1'h0, tck, tms;
  logic [1:0] cfg = 2'h0;
  logic [4:0] gp = 5'h04;
  logic [19:0] afs = 20'h00000;
  logic [4:0] keep [4] = '{5'h1F, 5'h0F, 5'h03, 5'h00};
  wire [4:0] pout, poe, ppu, ppd, gin, own, ain;
  wire [4:0] pin = {gp[4:2], tck, tms};
  wire [1:0] cfg_o;
  wire sdat, tclk, trise, tdi, trst;
  int n_fail = 0, n_checks = 0, cyc = 0, rises = 0;
  initial forever #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) rises <= rises + (trise === 1'h1);
  dbgp_probe_model i_dbgp_probe_model (.run_i(run), .tck_o(tck), .tms_o(tms));
  dbgp_pin_assign i_dbgp_pin_assign (.mclk_i, .reset_n_i, .system_reset_n_i(sys_n), .ce_i(ce), .cfg_we_i(we),
    .cfg_i(cfg), .trace_en_i(ten), .port_alt_function_select_i(afs), .pad_in_i(pin), .gpio_out_i(gp),
    .gpio_oe_i(~gp), .gpio_pu_i(5'h15), .gpio_pd_i(5'h02), .alt_out_i(gp), .alt_oe_i(gp),
    .dbg_swdio_out_i(gp[0]), .dbg_swdio_oe_i(gp[1]), .dbg_tdo_i(gp[2]), .dbg_tdo_oe_i(gp[3]),
    .async_trace_output_i(~gp[2]), .pad_out_o(pout), .pad_oe_o(poe), .pad_pu_o(ppu), .pad_pd_o(ppd),
    .gpio_in_o(gin), .alt_in_o(ain), .mode_select_or_serial_data_o(sdat), .test_or_serial_clock_o(tclk),
    .test_clock_rise_o(trise), .test_data_in_o(tdi), .test_reset_n_o(trst), .cfg_o(cfg_o), .debug_owned_o(own));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic set_cfg(input logic [1:0] c);
    @(posedge mclk_i);
    cfg <= c;
    we <= 1'h1;
    @(posedge mclk_i);
    we <= 1'h0;
    step(6);
  endtask
  task automatic t_reset();
    chk(own, 5'h1F);
    chk(cfg_o, 2'h0);
    chk({ppu, ppd}, 10'h2A2);
    chk(pout[3], 1'h1);
    chk({trst, tdi, sdat, tclk}, 4'hE);
  endtask
  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      set_cfg(k[1:0]);
      chk(cfg_o, k[1:0]);
      chk(own, keep[k]);
    end
    chk({trst, tdi}, 2'h3);
    @(posedge mclk_i);
    gp <= 5'h1F;
    step(6);
    chk({poe, ppu, ppd}, 15'h02A2);
    chk(gin, pin);
    @(posedge mclk_i);
    gp <= 5'h00;
    step(1);
    chk({poe, pout}, 10'h3E0);
  endtask
  task automatic t_sysrst();
    // Write during system reset must be dropped
    @(posedge mclk_i);
    sys_n <= 1'h0;
    we <= 1'h1;
    @(posedge mclk_i);
    sys_n <= 1'h1;
    we <= 1'h0;
    step(2);
    chk({cfg_o, own}, 7'h1F);
    chk({trst, tdi}, 2'h0);
  endtask
  task automatic t_ce();
    // Write while frozen must not land; pin change lands once unfrozen
    @(posedge mclk_i);
    ce <= 1'h0;
    we <= 1'h1;
    cfg <= 2'h3;
    gp <= 5'h1C;
    step(8);
    chk({cfg_o, own}, 7'h1F);
    @(posedge mclk_i);
    ce <= 1'h1;
    we <= 1'h0;
    step(8);
    chk({cfg_o, own}, 7'h1F);
    chk({trst, tdi}, 2'h3);
  endtask
  task automatic t_trace();
    @(posedge mclk_i);
    ten <= 1'h1;
    gp <= 5'h04;
    afs <= 20'h00500;
    step(6);
    chk(pout[3:2], 2'h1);
    chk(own, 5'h1B);
    chk(ain, 5'h04);
    @(posedge mclk_i);
    ten <= 1'h0;
    afs <= 20'h00000;
  endtask
  task automatic t_swd();
    int r0;
    set_cfg(2'h2);
    r0 = rises;
    run = 1'h1;
    repeat (8) @(posedge tck);
    run = 1'h0;
    step(20);
    chk(rises - r0, 16'h8);
    chk({tclk, sdat}, {1'h0, tms});
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    step(1);
    t_reset();
    t_modes();
    t_sysrst();
    t_ce();
    t_trace();
    t_swd();
    test_done();
  end
endmodule // tb_top
